// ---- design/dma_ctl_pkg.sv ----
package dma_ctl_pkg;

    localparam int NUM_CH = 5;

    // register offsets on the special function register bus
    localparam logic [7:0] ADDR_DONE_FLAGS = 8'hD1;
    localparam logic [7:0] ADDR_SHARED_PTR_LOW = 8'hD2;
    localparam logic [7:0] ADDR_SHARED_PTR_HIGH = 8'hD3;
    localparam logic [7:0] ADDR_FIRST_PTR_LOW = 8'hD4;
    localparam logic [7:0] ADDR_FIRST_PTR_HIGH = 8'hD5;
    localparam logic [7:0] ADDR_ARM_ABORT = 8'hD6;
    localparam logic [7:0] ADDR_MANUAL_REQ = 8'hD7;

    // field positions
    localparam int ABORT_BIT = 7;
    localparam int CH_LSB = 0;
    localparam int CH_MSB = 4;

    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] RESET_CH = 5'h00;
    localparam logic [15:0] RESET_PTR = 16'h0000;

    // size in bytes of one descriptor record
    localparam logic [15:0] DESC_BYTES = 16'h0008;

endpackage

// ---- design/dma_desc_addr.sv ----
`timescale 1ns/1ps
// forms the descriptor fetch address of the selected channel
module dma_desc_addr (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] ch_sel,
    input wire logic [15:0] first_ptr,
    input wire logic [15:0] shared_ptr,
    output logic [15:0] desc_addr
);

    logic [15:0] desc_addr_d;
    logic [15:0] desc_addr_q;

    always_comb begin
        if (ch_sel == 3'h0) begin
            desc_addr_d = first_ptr;
        end else begin
            // channels 1..4 use consecutive records starting at the shared base
            desc_addr_d = 16'(shared_ptr + 16'(dma_ctl_pkg::DESC_BYTES * 16'(ch_sel - 3'h1)));
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            desc_addr_q <= dma_ctl_pkg::RESET_PTR;
        end else begin
            desc_addr_q <= desc_addr_d;
        end
    end

    assign desc_addr = desc_addr_q;

endmodule // dma_desc_addr

// ---- design/dma_channel_control.sv ----
`timescale 1ns/1ps
// What this block does
// - writing abort with arm bits set stops and disarms those selected channels
// - a channel triggers no transfer unless its arm bit is one
// - count reached clears arm bit in single modes, keeps it in repeat modes
// - writing one to a manual request bit acts as one trigger event
// - manual request clears on grant; writing zero does nothing
// - channel 0 descriptor address is a 16-bit pointer, high and low bytes, reset zero
// - channels 1 to 4 share one 16-bit descriptor base pointer
// - done flag sets to one when channel reaches count, zero before
// - flags and arm bits reset to zero; unused upper bits read zero
// - interrupt request only when descriptor mask is one; flag set regardless
module dma_channel_control #(
    parameter int NUM_CH = dma_ctl_pkg::NUM_CH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [NUM_CH-1:0] hw_trigger,
    input wire logic [NUM_CH-1:0] grant,
    input wire logic [NUM_CH-1:0] count_reached,
    input wire logic [NUM_CH-1:0] repeat_mode,
    input wire logic [NUM_CH-1:0] channel_interrupt_mask,
    input wire logic [2:0] desc_ch_sel,
    output logic [NUM_CH-1:0] channel_arm,
    output logic [NUM_CH-1:0] manual_trigger_request,
    output logic [NUM_CH-1:0] trigger_event,
    output logic [NUM_CH-1:0] abort_channel,
    output logic [NUM_CH-1:0] channel_irq,
    output logic [NUM_CH-1:0] channel_done_flags,
    output logic [15:0] desc_addr
);

    logic [NUM_CH-1:0] arm_d;
    logic [NUM_CH-1:0] arm_q;
    logic [NUM_CH-1:0] req_d;
    logic [NUM_CH-1:0] req_q;
    logic [NUM_CH-1:0] done_d;
    logic [NUM_CH-1:0] done_q;
    logic [NUM_CH-1:0] trig_d;
    logic [NUM_CH-1:0] trig_q;
    logic [NUM_CH-1:0] abort_d;
    logic [NUM_CH-1:0] abort_q;
    logic [NUM_CH-1:0] irq_d;
    logic [NUM_CH-1:0] irq_q;
    logic [7:0] first_low_d;
    logic [7:0] first_low_q;
    logic [7:0] first_high_d;
    logic [7:0] first_high_q;
    logic [7:0] shared_low_d;
    logic [7:0] shared_low_q;
    logic [7:0] shared_high_d;
    logic [7:0] shared_high_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic [NUM_CH-1:0] wr_ch;
    logic wr_arm;
    logic wr_req;
    logic wr_done;
    logic abort_wr;
    logic [7:0] arm_rd;
    logic [7:0] req_rd;
    logic [7:0] done_rd;
    logic [15:0] first_ptr;
    logic [15:0] shared_ptr;

    assign wr_ch = sfr_wdata[NUM_CH-1:0];
    assign wr_arm = sfr_wr && (sfr_addr == dma_ctl_pkg::ADDR_ARM_ABORT);
    assign wr_req = sfr_wr && (sfr_addr == dma_ctl_pkg::ADDR_MANUAL_REQ);
    assign wr_done = sfr_wr && (sfr_addr == dma_ctl_pkg::ADDR_DONE_FLAGS);
    assign abort_wr = wr_arm && sfr_wdata[dma_ctl_pkg::ABORT_BIT];
    assign first_ptr = {first_high_q, first_low_q};
    assign shared_ptr = {shared_high_q, shared_low_q};

    // per-channel control bits
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            // arm bit and abort strobe
            always_comb begin
                arm_d[ch] = arm_q[ch];
                if (abort_wr) begin
                    if (wr_ch[ch]) begin
                        arm_d[ch] = 1'b0;
                    end
                end else if (wr_arm) begin
                    arm_d[ch] = wr_ch[ch];
                end
                if (count_reached[ch] && arm_q[ch] && !repeat_mode[ch]) begin
                    arm_d[ch] = 1'b0;
                end
                abort_d[ch] = abort_wr && wr_ch[ch];
            end

            // manual request and trigger pulse
            always_comb begin
                // set beats the grant clear; a zero write leaves the bit alone
                req_d[ch] = (req_q[ch] && !grant[ch]) || (wr_req && wr_ch[ch]);
                // a manual set counts as one trigger, only while armed
                trig_d[ch] = arm_q[ch] && !(abort_wr && wr_ch[ch])
                    && (hw_trigger[ch] || (wr_req && wr_ch[ch] && !req_q[ch]));
            end

            // completion flag and interrupt pulse
            always_comb begin
                done_d[ch] = done_q[ch];
                if (wr_done && !wr_ch[ch]) begin
                    done_d[ch] = 1'b0;
                end
                if (count_reached[ch] && arm_q[ch]) begin
                    done_d[ch] = 1'b1;
                end
                irq_d[ch] = count_reached[ch] && arm_q[ch] && channel_interrupt_mask[ch];
            end
        end
    endgenerate

    // pointer bytes are written one at a time, with no high/low latching
    always_comb begin
        first_low_d = first_low_q;
        first_high_d = first_high_q;
        shared_low_d = shared_low_q;
        shared_high_d = shared_high_q;
        if (sfr_wr) begin
            unique case (sfr_addr)
                dma_ctl_pkg::ADDR_FIRST_PTR_LOW: first_low_d = sfr_wdata;
                dma_ctl_pkg::ADDR_FIRST_PTR_HIGH: first_high_d = sfr_wdata;
                dma_ctl_pkg::ADDR_SHARED_PTR_LOW: shared_low_d = sfr_wdata;
                dma_ctl_pkg::ADDR_SHARED_PTR_HIGH: shared_high_d = sfr_wdata;
                default: ;
            endcase
        end
    end

    // read data: abort and the unused upper bits always read zero
    always_comb begin
        arm_rd = dma_ctl_pkg::RESET_BYTE;
        req_rd = dma_ctl_pkg::RESET_BYTE;
        done_rd = dma_ctl_pkg::RESET_BYTE;
        arm_rd[NUM_CH-1:0] = arm_q;
        req_rd[NUM_CH-1:0] = req_q;
        done_rd[NUM_CH-1:0] = done_q;
        rdata_d = dma_ctl_pkg::RESET_BYTE;
        unique case (sfr_addr)
            dma_ctl_pkg::ADDR_ARM_ABORT: rdata_d = arm_rd;
            dma_ctl_pkg::ADDR_MANUAL_REQ: rdata_d = req_rd;
            dma_ctl_pkg::ADDR_DONE_FLAGS: rdata_d = done_rd;
            dma_ctl_pkg::ADDR_FIRST_PTR_LOW: rdata_d = first_low_q;
            dma_ctl_pkg::ADDR_FIRST_PTR_HIGH: rdata_d = first_high_q;
            dma_ctl_pkg::ADDR_SHARED_PTR_LOW: rdata_d = shared_low_q;
            dma_ctl_pkg::ADDR_SHARED_PTR_HIGH: rdata_d = shared_high_q;
            default: rdata_d = dma_ctl_pkg::RESET_BYTE;
        endcase
    end

    // channel control state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arm_q <= dma_ctl_pkg::RESET_CH;
            req_q <= dma_ctl_pkg::RESET_CH;
            done_q <= dma_ctl_pkg::RESET_CH;
            trig_q <= dma_ctl_pkg::RESET_CH;
            abort_q <= dma_ctl_pkg::RESET_CH;
            irq_q <= dma_ctl_pkg::RESET_CH;
        end else begin
            arm_q <= arm_d;
            req_q <= req_d;
            done_q <= done_d;
            trig_q <= trig_d;
            abort_q <= abort_d;
            irq_q <= irq_d;
        end
    end

    // descriptor pointer bytes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            first_low_q <= dma_ctl_pkg::RESET_BYTE;
            first_high_q <= dma_ctl_pkg::RESET_BYTE;
            shared_low_q <= dma_ctl_pkg::RESET_BYTE;
            shared_high_q <= dma_ctl_pkg::RESET_BYTE;
        end else begin
            first_low_q <= first_low_d;
            first_high_q <= first_high_d;
            shared_low_q <= shared_low_d;
            shared_high_q <= shared_high_d;
        end
    end

    // registered, so a read answers one cycle after its address
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= dma_ctl_pkg::RESET_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    dma_desc_addr u_desc_addr (
        .clk(clk),
        .rstn(rstn),
        .ch_sel(desc_ch_sel),
        .first_ptr(first_ptr),
        .shared_ptr(shared_ptr),
        .desc_addr(desc_addr)
    );

    assign sfr_rdata = rdata_q;
    assign channel_arm = arm_q;
    assign manual_trigger_request = req_q;
    assign trigger_event = trig_q;
    assign abort_channel = abort_q;
    assign channel_irq = irq_q;
    assign channel_done_flags = done_q;

endmodule // dma_channel_control

// ---- bench/dma_ctl_chk_sva.sv ----
`timescale 1ns/1ps
module dma_ctl_chk #(
    parameter int NUM_CH = 5
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [NUM_CH-1:0] grant,
    input wire logic [NUM_CH-1:0] count_reached,
    input wire logic [NUM_CH-1:0] repeat_mode,
    input wire logic [NUM_CH-1:0] channel_interrupt_mask,
    input wire logic [NUM_CH-1:0] channel_arm,
    input wire logic [NUM_CH-1:0] manual_trigger_request,
    input wire logic [NUM_CH-1:0] trigger_event,
    input wire logic [NUM_CH-1:0] abort_channel,
    input wire logic [NUM_CH-1:0] channel_irq,
    input wire logic [NUM_CH-1:0] channel_done_flags
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_abort_wr;
        sfr_wr && sfr_addr == dma_ctl_pkg::ADDR_ARM_ABORT && sfr_wdata[7];
    endsequence
    sequence s_req_wr;
        sfr_wr && sfr_addr == dma_ctl_pkg::ADDR_MANUAL_REQ;
    endsequence
    chk_abort_disarm: assert property (s_abort_wr |=> (channel_arm & $past(sfr_wdata[4:0])) == 0)
        else $error("abort left a channel armed");
    chk_abort_only_strobe: assert property (
        !(sfr_wr && sfr_addr == dma_ctl_pkg::ADDR_ARM_ABORT && sfr_wdata[dma_ctl_pkg::ABORT_BIT])
        |=> abort_channel == 0)
        else $error("abort pulse without abort write");
    chk_arm_gates_trigger: assert property ((trigger_event & ~$past(channel_arm)) == 0)
        else $error("trigger on unarmed channel");
    chk_manual_trig: assert property (
        s_req_wr ##0 (sfr_wdata[4:0] & channel_arm & ~manual_trigger_request) != 0 |=> trigger_event != 0)
        else $error("manual request gave no trigger");
    chk_grant_clear: assert property (grant != 0 && !sfr_wr |=> (manual_trigger_request & $past(grant)) == 0)
        else $error("grant did not clear request");
    chk_done_set: assert property ((count_reached & channel_arm) != 0 |=>
        (channel_done_flags & $past(count_reached) & $past(channel_arm)) == ($past(count_reached) & $past(channel_arm)))
        else $error("done flag not set");
    chk_single_disarm: assert property ((count_reached & channel_arm & ~repeat_mode) != 0 |=>
        (channel_arm & $past(count_reached) & ~$past(repeat_mode)) == 0)
        else $error("arm kept in single mode");
    chk_irq_mask: assert property ((channel_irq & ~$past(channel_interrupt_mask)) == 0)
        else $error("irq while masked");
    chk_upper_zero: assert property (sfr_addr inside {8'hD1, 8'hD6, 8'hD7} |=> sfr_rdata[7:5] == 0)
        else $error("unused bits read nonzero");
endmodule // dma_ctl_chk
bind dma_channel_control dma_ctl_chk #(.NUM_CH(NUM_CH)) chk_u (.clk, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_rdata, .grant, .count_reached, .repeat_mode, .channel_interrupt_mask, .channel_arm,
    .manual_trigger_request, .trigger_event, .abort_channel, .channel_irq, .channel_done_flags);

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rstn = 0, sfr_wr = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [4:0] hw_trigger = 0, grant = 0, count_reached = 0, repeat_mode = 0, channel_interrupt_mask = 0;
    logic [4:0] channel_arm, manual_trigger_request, trigger_event, abort_channel, channel_irq, channel_done_flags;
    logic [2:0] desc_ch_sel = 3'h0;
    logic [15:0] desc_addr, fp, sp;
    logic [4:0] a, c, m;
    int failures = 0, comparisons = 0, seed = 91;
    always #20 clk = ~clk;
    dma_channel_control dut_u (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .hw_trigger(hw_trigger), .grant(grant), .count_reached(count_reached),
        .repeat_mode(repeat_mode), .channel_interrupt_mask(channel_interrupt_mask), .desc_ch_sel(desc_ch_sel),
        .channel_arm(channel_arm), .manual_trigger_request(manual_trigger_request), .trigger_event(trigger_event),
        .abort_channel(abort_channel), .channel_irq(channel_irq), .channel_done_flags(channel_done_flags),
        .desc_addr(desc_addr));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_addr <= ad;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= ad;
        @(posedge clk);
        #1 chk(sfr_rdata, e);
    endtask
    task automatic step(input logic [4:0] hw, input logic [4:0] gr, input logic [4:0] cr);
        @(posedge clk);
        hw_trigger <= hw;
        grant <= gr;
        count_reached <= cr;
        @(posedge clk);
        {hw_trigger, grant, count_reached} <= 15'h0000;
        #1;
    endtask
    function automatic logic [15:0] exp_addr(input int i);
        return i == 0 ? fp : 16'(sp + dma_ctl_pkg::DESC_BYTES * (i - 1));
    endfunction
    task automatic test_done();
        if (failures == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #80000;
        failures++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 'hD0; i <= 'hD8; i++) rd(8'(i), 8'h00);
        fp = 16'($random(seed));
        sp = 16'($random(seed));
        wr(8'hD5, fp[15:8]);
        wr(8'hD4, fp[7:0]);
        wr(8'hD3, sp[15:8]);
        wr(8'hD2, sp[7:0]);
        rd(8'hD5, fp[15:8]);
        rd(8'hD2, sp[7:0]);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            desc_ch_sel <= 3'(i);
            @(posedge clk);
            #1 chk(desc_addr, exp_addr(i));
        end
        wr(8'hD6, 8'h1F);
        wr(8'hD6, 8'h85);
        chk(abort_channel, 5'h05);
        chk(channel_arm, 5'h1A);
        rd(8'hD6, 8'h1A);
        wr(8'hD7, 8'h02);
        chk(trigger_event, 5'h02);
        wr(8'hD7, 8'h00);
        chk(manual_trigger_request, 5'h02);
        step(5'h00, 5'h02, 5'h00);
        chk(manual_trigger_request, 5'h00);
        step(5'h1F, 5'h00, 5'h00);
        chk(trigger_event, 5'h1A);
        for (int k = 0; k < 16; k++) begin
            a = 5'($random(seed));
            c = 5'($random(seed));
            m = 5'($random(seed));
            wr(8'hD1, 8'h00);
            wr(8'hD6, {3'h0, a});
            repeat_mode <= 5'($random(seed));
            channel_interrupt_mask <= m;
            step(5'h00, 5'h00, c);
            chk(channel_irq, a & c & m);
            chk(channel_arm, a & (repeat_mode | ~c));
            rd(8'hD1, {3'h0, a & c});
        end
        // second reset in mid-run: arm bits, flags and pointers return to zero
        wr(8'hD6, 8'h1F);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk(channel_arm, 5'h00);
        chk(channel_done_flags, 5'h00);
        chk(desc_addr, 16'h0000);
        rd(8'hD5, 8'h00);
        rd(8'hD3, 8'h00);
        test_done();
    end
endmodule // tb_top
